// ==== verilog/dcp_policy.sv ====
// DC output state policy controller, top level
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "dcp_cfg.svh"

// How it works
// R1 - With power-up policy off the output is held disabled after every power-up.
// R2 - With power-up policy restore the output state kept from last switch-off is re-applied.
// R3 - The power-up policy resets to off, both at factory reset and on a defaults command.
// R4 - With supply-loss policy off the output stays disabled after the alarm, even once cleared.
// R5 - With supply-loss policy auto the output returns when the alarm clears, if it was on before.
// R6 - With remote-exit policy off the output is disabled whenever remote control ends.
// R7 - With remote-exit policy auto the output keeps its state when remote control ends.
// R8 - With overheat policy off the output stays disabled after the alarm, even once cooled.
// R9 - With overheat policy auto the pre-alarm output state is restored once cooled.
// R10 - A role field selects master or slave, either of which enables parallel operation.
// R11 - A control bit switches the parallel bus termination resistor in or out.
// R12 - A separate control bit connects two bias resistors to the parallel bus.
// R13 - With the timeout enabled the backlight goes off after 60 s without user activity.
// R14 - A re-initialization trigger makes the master repeat discovery of its slaves.
// R15 - Any user activity restarts the backlight timer and relights the backlight.
// R16 - The output state at alarm onset is latched and drives the auto-restore decision.
module dcp_policy
  import dcp_pkg::*;
#(
  parameter int unsigned BLT_TIMEOUT = `DCP_BLT_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Power-up state
  input  wire logic        boot_done,
  input  wire logic        saved_out_on,
  // Events
  input  wire logic        supply_loss_alarm,
  input  wire logic        overheat_alarm,
  input  wire logic        remote_active,
  input  wire logic        user_activity,
  // Power stage, state store, parallel bus, backlight and interrupt
  output logic             dc_out_en,
  output logic             saved_out_on_q,
  output dcp_par_s         par_cfg,
  output logic             reinit_pulse,
  output logic             backlight_on,
  output logic             irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dcp_bus_s          bus;
  dcp_evt_s          evt;
  logic [4:0]        ctrl;
  logic [4:0]        next_ctrl;
  logic [3:0]        par;
  logic [3:0]        next_par;
  logic [`DCP_IRQ_W-1:0] irq_stat;
  logic [`DCP_IRQ_W-1:0] next_irq_stat;
  logic [`DCP_IRQ_W-1:0] irq_mask;
  logic [`DCP_IRQ_W-1:0] next_irq_mask;
  logic [31:0]       next_rdata;
  logic              next_dc_out_en;
  logic              next_saved;
  logic              next_reinit;
  logic              next_irq;
  logic              supply_prior;
  logic              next_supply_prior;
  logic              heat_prior;
  logic              next_heat_prior;
  logic              booted;
  logic              next_booted;
  logic              supply_rise;
  logic              supply_fall;
  logic              heat_rise;
  logic              heat_fall;
  logic              remote_fall;
  logic              boot_rise;
  logic              boot_fall;
  logic              blt_expired;
  logic              blt_on;
  logic              cmd_on;
  logic              cmd_off;
  logic              cmd_defaults;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign evt = '{supply_loss_alarm: supply_loss_alarm, overheat_alarm: overheat_alarm,
                 remote_active: remote_active, user_activity: user_activity};

  function automatic logic wr_hit(input dcp_bus_s b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  assign cmd_on       = wr_hit(bus, `DCP_ADDR_CMD) && bus.wdata[`DCP_CMD_OUT_ON];
  assign cmd_off      = wr_hit(bus, `DCP_ADDR_CMD) && bus.wdata[`DCP_CMD_OUT_OFF];
  assign cmd_defaults = wr_hit(bus, `DCP_ADDR_CMD) && bus.wdata[`DCP_CMD_DEFAULTS];

  // ****************************************************************
  // Event edges and backlight timer
  // ****************************************************************
  dcp_edge u_supply_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (evt.supply_loss_alarm),
    .rise  (supply_rise),
    .fall  (supply_fall)
  );

  dcp_edge u_heat_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (evt.overheat_alarm),
    .rise  (heat_rise),
    .fall  (heat_fall)
  );

  dcp_edge u_remote_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (evt.remote_active),
    .rise  (),
    .fall  (remote_fall)
  );

  dcp_edge u_boot_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (boot_done),
    .rise  (boot_rise),
    .fall  (boot_fall)
  );

  dcp_blt_timer #(
    .TIMEOUT (BLT_TIMEOUT)
  ) u_blt (
    .clk          (clk),
    .rst_n        (rst_n),
    .enable       (ctrl[`DCP_CTRL_BLT_EN]),
    .activity     (evt.user_activity),
    .backlight_on (blt_on),
    .expired      (blt_expired)
  );

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_comb
  begin
    next_ctrl     = ctrl;
    next_par      = par;
    next_irq_mask = irq_mask;
    next_reinit   = 1'b0;
    if (cmd_defaults)
    begin
      next_ctrl = `DCP_CTRL_RESET;                              // [R3]
      next_par  = `DCP_PAR_RESET;
    end
    else if (wr_hit(bus, `DCP_ADDR_CTRL))
      next_ctrl = bus.wdata[4:0];
    if (!cmd_defaults && wr_hit(bus, `DCP_ADDR_PAR))
      next_par = bus.wdata[3:0];                                // [R10] [R11] [R12]
    if (wr_hit(bus, `DCP_ADDR_IRQ_MASK))
      next_irq_mask = bus.wdata[`DCP_IRQ_W-1:0];
    if (wr_hit(bus, `DCP_ADDR_CMD) && bus.wdata[`DCP_CMD_REINIT]
        && par[1:0] == DCP_ROLE_MASTER)
      next_reinit = 1'b1;                                       // [R14]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl         <= `DCP_CTRL_RESET;                          // [R3]
      par          <= `DCP_PAR_RESET;
      irq_mask     <= '0;
      reinit_pulse <= 1'b0;
    end
    else
    begin
      ctrl         <= next_ctrl;
      par          <= next_par;
      irq_mask     <= next_irq_mask;
      reinit_pulse <= next_reinit;
    end
  end

  // ****************************************************************
  // DC output policy
  // ****************************************************************
  always_comb
  begin
    next_dc_out_en    = dc_out_en;
    next_supply_prior = supply_prior;
    next_heat_prior   = heat_prior;
    next_booted       = booted;
    if (boot_fall)
      next_booted = 1'b0;
    if (boot_rise && !booted)
    begin
      next_booted    = 1'b1;
      next_dc_out_en = ctrl[`DCP_CTRL_PWRUP] ? saved_out_on : 1'b0; // [R1] [R2]
    end
    else if (cmd_on && !evt.supply_loss_alarm && !evt.overheat_alarm)
      next_dc_out_en = 1'b1;
    else if (cmd_off)
      next_dc_out_en = 1'b0;
    if (supply_fall && !evt.overheat_alarm)
      next_dc_out_en = ctrl[`DCP_CTRL_SUPPLY] && supply_prior
                       && (!heat_fall || (ctrl[`DCP_CTRL_HEAT] && heat_prior)); // [R4] [R5]
    if (heat_fall && !evt.supply_loss_alarm && !supply_fall)
      next_dc_out_en = ctrl[`DCP_CTRL_HEAT] && heat_prior;      // [R8] [R9]
    // Leaving remote with policy off beats any alarm restore
    if (remote_fall && !ctrl[`DCP_CTRL_REMOTE])
      next_dc_out_en = 1'b0;                                    // [R6] [R7]
    if (supply_rise)
      next_supply_prior = next_dc_out_en;                       // [R16]
    if (heat_rise)
      next_heat_prior = next_dc_out_en;                         // [R16]
    if (evt.supply_loss_alarm || evt.overheat_alarm)
      next_dc_out_en = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dc_out_en    <= 1'b0;                                     // [R1]
      supply_prior <= 1'b0;
      heat_prior   <= 1'b0;
      booted       <= 1'b0;
    end
    else
    begin
      dc_out_en    <= next_dc_out_en;
      supply_prior <= next_supply_prior;
      heat_prior   <= next_heat_prior;
      booted       <= next_booted;
    end
  end

  // Kept copy of the output state for the next power-up
  always_comb
  begin
    next_saved = dc_out_en;                                     // [R2]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      saved_out_on_q <= 1'b0;
    else
      saved_out_on_q <= next_saved;
  end

  // ****************************************************************
  // Interrupts and read data
  // ****************************************************************
  always_comb
  begin
    next_irq_stat = irq_stat;
    if (wr_hit(bus, `DCP_ADDR_IRQ_STAT))
      next_irq_stat = irq_stat & ~bus.wdata[`DCP_IRQ_W-1:0];
    // Set wins over clear
    next_irq_stat[`DCP_IRQ_SUPPLY] = next_irq_stat[`DCP_IRQ_SUPPLY] | supply_rise;
    next_irq_stat[`DCP_IRQ_HEAT]   = next_irq_stat[`DCP_IRQ_HEAT] | heat_rise;
    next_irq_stat[`DCP_IRQ_REMOTE] = next_irq_stat[`DCP_IRQ_REMOTE] | remote_fall;
    next_irq_stat[`DCP_IRQ_BLT]    = next_irq_stat[`DCP_IRQ_BLT] | blt_expired;
    next_irq = |(next_irq_stat & irq_mask);
    next_rdata = 32'h0;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `DCP_ADDR_CTRL:     next_rdata = {27'h0, ctrl};
        `DCP_ADDR_PAR:      next_rdata = {28'h0, par};
        `DCP_ADDR_STATUS:   next_rdata = {26'h0, blt_on, remote_active, overheat_alarm,
                                          supply_loss_alarm, booted, dc_out_en};
        `DCP_ADDR_IRQ_STAT: next_rdata = {28'h0, irq_stat};
        `DCP_ADDR_IRQ_MASK: next_rdata = {28'h0, irq_mask};
        default:            next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_stat  <= '0;
      irq       <= 1'b0;
      reg_rdata <= 32'h0;
    end
    else
    begin
      irq_stat  <= next_irq_stat;
      irq       <= next_irq;
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      par_cfg      <= '{parallel_group_mode: DCP_ROLE_NONE, term_en: 1'b0, bias_en: 1'b0};
      backlight_on <= 1'b1;
    end
    else
    begin
      par_cfg.parallel_group_mode <= dcp_role_e'(par[1:0]);    // [R10]
      par_cfg.term_en             <= par[`DCP_PAR_TERM];       // [R11]
      par_cfg.bias_en             <= par[`DCP_PAR_BIAS];       // [R12]
      backlight_on                <= blt_on;                   // [R13]
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_boot_up;
    boot_rise && !booted;
  endsequence

  chk_pwrup_off: assert property (@(posedge clk) disable iff (!rst_n)
    (s_boot_up and !ctrl[`DCP_CTRL_PWRUP]) |=> !dc_out_en)      // [R1]
    else $error("output on after power-up with policy off");
  chk_pwrup_restore: assert property (@(posedge clk) disable iff (!rst_n)
    (s_boot_up and ctrl[`DCP_CTRL_PWRUP] && !supply_loss_alarm && !overheat_alarm
     && !remote_fall && !supply_fall && !heat_fall)
      |=> dc_out_en == $past(saved_out_on))                      // [R2]
    else $error("power-up restore mismatch");
  chk_defaults: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_defaults |=> !ctrl[`DCP_CTRL_PWRUP])                    // [R3]
    else $error("defaults left power-up policy set");
  chk_supply_off: assert property (@(posedge clk) disable iff (!rst_n)
    (supply_fall && !ctrl[`DCP_CTRL_SUPPLY]) |=> !dc_out_en)    // [R4]
    else $error("output on after supply loss with policy off");
  chk_supply_auto: assert property (@(posedge clk) disable iff (!rst_n)
    (supply_fall && !overheat_alarm && ctrl[`DCP_CTRL_SUPPLY] && !heat_fall && !remote_fall)
      |=> dc_out_en == $past(supply_prior))                      // [R5] [R16]
    else $error("supply loss auto restore mismatch");
  chk_remote_off: assert property (@(posedge clk) disable iff (!rst_n)
    (remote_fall && !ctrl[`DCP_CTRL_REMOTE]) |=> !dc_out_en)    // [R6]
    else $error("output on after leaving remote");
  chk_heat_off: assert property (@(posedge clk) disable iff (!rst_n)
    (heat_fall && !ctrl[`DCP_CTRL_HEAT]) |=> !dc_out_en)        // [R8]
    else $error("output on after overheat with policy off");
  chk_heat_auto: assert property (@(posedge clk) disable iff (!rst_n)
    (heat_fall && !supply_loss_alarm && ctrl[`DCP_CTRL_HEAT] && !supply_fall && !remote_fall)
      |=> dc_out_en == $past(heat_prior))                        // [R9] [R16]
    else $error("overheat auto restore mismatch");
  chk_reinit_master: assert property (@(posedge clk) disable iff (!rst_n)
    reinit_pulse |-> $past(par[1:0]) == DCP_ROLE_MASTER)         // [R14]
    else $error("reinit issued while not master");

endmodule // dcp_policy

// ==== verilog/dcp_cfg.svh ====
// Constants for the DC output state policy block
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

// ****************************************************************
// Register offsets (8-bit address)
// ****************************************************************
`define DCP_ADDR_CTRL     8'h00
`define DCP_ADDR_PAR      8'h04
`define DCP_ADDR_STATUS   8'h08
`define DCP_ADDR_IRQ_STAT 8'h0C
`define DCP_ADDR_IRQ_MASK 8'h10
`define DCP_ADDR_CMD      8'h14

// ****************************************************************
// Control register fields
// ****************************************************************
`define DCP_CTRL_PWRUP    0
`define DCP_CTRL_SUPPLY   1
`define DCP_CTRL_REMOTE   2
`define DCP_CTRL_HEAT     3
`define DCP_CTRL_BLT_EN   4
`define DCP_CTRL_RESET    5'h18

// ****************************************************************
// Parallel register fields
// ****************************************************************
`define DCP_PAR_ROLE_LSB  0
`define DCP_PAR_TERM      2
`define DCP_PAR_BIAS      3
`define DCP_PAR_RESET     4'h0

// ****************************************************************
// Command register bits (write-only pulses)
// ****************************************************************
`define DCP_CMD_OUT_ON    0
`define DCP_CMD_OUT_OFF   1
`define DCP_CMD_REINIT    2
`define DCP_CMD_DEFAULTS  3

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define DCP_IRQ_SUPPLY    0
`define DCP_IRQ_HEAT      1
`define DCP_IRQ_REMOTE    2
`define DCP_IRQ_BLT       3
`define DCP_IRQ_W         4

// ****************************************************************
// Timing
// ****************************************************************
`define DCP_CLK_HZ        10000000
`define DCP_BLT_SEC       60
`define DCP_BLT_CYCLES    (`DCP_BLT_SEC * `DCP_CLK_HZ)

`endif

// ==== verilog/dcp_pkg.sv ====
// Types of the DC output state policy block
package dcp_pkg;

  typedef enum logic [1:0] {
    DCP_ROLE_NONE   = 2'h0,
    DCP_ROLE_MASTER = 2'h1,
    DCP_ROLE_SLAVE  = 2'h2
  } dcp_role_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dcp_bus_s;

  typedef struct packed {
    logic supply_loss_alarm;
    logic overheat_alarm;
    logic remote_active;
    logic user_activity;
  } dcp_evt_s;

  typedef struct packed {
    dcp_role_e parallel_group_mode;
    logic      term_en;
    logic      bias_en;
  } dcp_par_s;

endpackage

// ==== verilog/dcp_edge.sv ====
// Rise and fall detector on a registered level
`timescale 1ns/1ps

module dcp_edge
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in, pulses out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev;
  logic next_prev;

  always_comb
  begin
    next_prev = level;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prev <= 1'b0;
    else
      prev <= next_prev;
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule // dcp_edge

// ==== verilog/dcp_blt_timer.sv ====
// Display backlight inactivity timer
`timescale 1ns/1ps
`include "dcp_cfg.svh"

module dcp_blt_timer
#(
  parameter int unsigned TIMEOUT = `DCP_BLT_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic activity,
  // Status
  output logic      backlight_on,
  output logic      expired
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_backlight_on;
  logic        next_expired;

  always_comb
  begin
    next_count        = count;
    next_backlight_on = backlight_on;
    next_expired      = 1'b0;
    if (activity || !enable)
    begin
      // Any activity restarts the count and lights the display
      next_count        = 32'h0;                                // [R15]
      next_backlight_on = 1'b1;                                 // [R15]
    end
    else if (backlight_on)
    begin
      if (count >= TIMEOUT - 1)
      begin
        next_backlight_on = 1'b0;                               // [R13]
        next_expired      = 1'b1;
      end
      else
        next_count = count + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count        <= 32'h0;
      backlight_on <= 1'b1;
      expired      <= 1'b0;
    end
    else
    begin
      count        <= next_count;
      backlight_on <= next_backlight_on;
      expired      <= next_expired;
    end
  end

  chk_activity_relights: assert property (@(posedge clk) disable iff (!rst_n)
    activity |=> backlight_on && count == 32'h0)                 // [R15]
    else $error("activity did not relight backlight");

  chk_timeout_off: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && !activity && backlight_on && count == TIMEOUT - 1) |=> !backlight_on) // [R13]
    else $error("backlight not off at timeout");

endmodule // dcp_blt_timer

// ==== dv/dcp_stage_model.sv ====
// Behavioural model of the power stage, alarm sensing and nonvolatile state store
`timescale 1ns/1ps

module dcp_stage_model
(
  // Clock
  input  wire logic clk,
  // Requests from the bench
  input  wire logic power_req,
  input  wire logic supply_req,
  input  wire logic heat_req,
  // From the policy block
  input  wire logic saved_out_on_q,
  // To the policy block
  output logic      boot_done,
  output logic      supply_loss_alarm,
  output logic      overheat_alarm,
  output logic      saved_out_on
);
  // Alarm sensing and boot sequencing, one register stage each
  always_ff @(posedge clk)
  begin
    boot_done         <= power_req;
    supply_loss_alarm <= supply_req;
    overheat_alarm    <= heat_req;
  end

  // Store follows the output only while powered, so it holds across a power cycle
  always_ff @(posedge clk)
  begin
    if (boot_done)
      saved_out_on <= saved_out_on_q;
  end
endmodule // dcp_stage_model

// ==== dv/testbench.sv ====
// Self-checking testbench of the DC output state policy block
`timescale 1ns/1ps
`include "dcp_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  import dcp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        remote_active = 1'b0;
  logic        user_activity = 1'b0;
  logic        power_req = 1'b0;
  logic        supply_req = 1'b0;
  logic        heat_req = 1'b0;
  logic        boot_done, saved_out_on, supply_loss_alarm, overheat_alarm;
  logic        dc_out_en, saved_out_on_q, reinit_pulse, backlight_on, irq;
  dcp_par_s    par_cfg;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  dcp_policy #(.BLT_TIMEOUT(20)) dcp_policy_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_done(boot_done),
    .saved_out_on(saved_out_on), .supply_loss_alarm(supply_loss_alarm),
    .overheat_alarm(overheat_alarm), .remote_active(remote_active),
    .user_activity(user_activity), .dc_out_en(dc_out_en), .saved_out_on_q(saved_out_on_q),
    .par_cfg(par_cfg), .reinit_pulse(reinit_pulse), .backlight_on(backlight_on), .irq(irq));

  dcp_stage_model dcp_stage_model_i (
    .clk(clk), .power_req(power_req), .supply_req(supply_req), .heat_req(heat_req),
    .saved_out_on_q(saved_out_on_q), .boot_done(boot_done),
    .supply_loss_alarm(supply_loss_alarm), .overheat_alarm(overheat_alarm),
    .saved_out_on(saved_out_on));

  // ****************************************************************
  // Bus cycles and helpers
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic power_cycle;
    @(posedge clk) power_req <= 1'b0;
    settle;
    @(posedge clk) power_req <= 1'b1;
    settle;
  endtask

  task automatic reinit_seen(output logic got);
    got = 1'b0;
    repeat (4)
    begin
      #1 if (reinit_pulse === 1'b1) got = 1'b1;
      @(posedge clk);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(`DCP_ADDR_CTRL, 32'h18);
    rd(`DCP_ADDR_PAR, 32'h0);
    rd(8'hFC, 32'h0);
    rd(`DCP_ADDR_STATUS, 32'h20);
    `CHK(dc_out_en, 1'b0)
  endtask

  task automatic t_power;
    @(posedge clk) power_req <= 1'b1;
    settle;
    `CHK(dc_out_en, 1'b0)
    wr(`DCP_ADDR_CMD, 32'h1);
    settle;
    `CHK(saved_out_on_q, 1'b1)
    power_cycle;
    `CHK(dc_out_en, 1'b0)
    wr(`DCP_ADDR_CMD, 32'h1);
    wr(`DCP_ADDR_CTRL, 32'h19);
    power_cycle;
    `CHK(dc_out_en, 1'b1)
    wr(`DCP_ADDR_CMD, 32'h2);
    power_cycle;
    `CHK(dc_out_en, 1'b0)
    wr(`DCP_ADDR_CMD, 32'h8);
    rd(`DCP_ADDR_CTRL, 32'h18);
  endtask

  task automatic alarm_run(input logic heat, input logic [31:0] ctrl, input logic on,
                           input logic exp);
    wr(`DCP_ADDR_CTRL, ctrl);
    wr(`DCP_ADDR_CMD, on ? 32'h1 : 32'h2);
    settle;
    @(posedge clk)
    begin
      heat_req   <= heat;
      supply_req <= ~heat;
    end
    settle;
    `CHK(dc_out_en, 1'b0)
    wr(`DCP_ADDR_CMD, 32'h1);
    settle;
    `CHK(dc_out_en, 1'b0)
    @(posedge clk)
    begin
      heat_req   <= 1'b0;
      supply_req <= 1'b0;
    end
    settle;
    `CHK(dc_out_en, exp)
  endtask

  task automatic t_supply;
    wr(`DCP_ADDR_IRQ_STAT, 32'hF);
    wr(`DCP_ADDR_IRQ_MASK, 32'h1);
    alarm_run(1'b0, 32'h18, 1'b1, 1'b0);
    `CHK(irq, 1'b1)
    wr(`DCP_ADDR_IRQ_STAT, 32'h1);
    settle;
    `CHK(irq, 1'b0)
    alarm_run(1'b0, 32'h1A, 1'b1, 1'b1);
    alarm_run(1'b0, 32'h1A, 1'b0, 1'b0);
    wr(`DCP_ADDR_IRQ_MASK, 32'h0);
  endtask

  task automatic t_heat;
    alarm_run(1'b1, 32'h18, 1'b1, 1'b1);
    alarm_run(1'b1, 32'h10, 1'b1, 1'b0);
    alarm_run(1'b1, 32'h18, 1'b0, 1'b0);
  endtask

  task automatic t_remote(input logic [31:0] ctrl, input logic on, input logic exp);
    wr(`DCP_ADDR_CTRL, ctrl);
    wr(`DCP_ADDR_CMD, on ? 32'h1 : 32'h2);
    @(posedge clk) remote_active <= 1'b1;
    settle;
    `CHK(dc_out_en, on)
    @(posedge clk) remote_active <= 1'b0;
    settle;
    `CHK(dc_out_en, exp)
  endtask

  task automatic t_par;
    logic got;
    wr(`DCP_ADDR_PAR, 32'hD);
    settle;
    `CHK(par_cfg, 4'h7)
    rd(`DCP_ADDR_PAR, 32'hD);
    wr(`DCP_ADDR_CMD, 32'h4);
    reinit_seen(got);
    `CHK(got, 1'b1)
    wr(`DCP_ADDR_PAR, 32'h2);
    settle;
    `CHK(par_cfg, 4'h8)
    wr(`DCP_ADDR_CMD, 32'h4);
    reinit_seen(got);
    `CHK(got, 1'b0)
    wr(`DCP_ADDR_PAR, 32'h4);
    settle;
    `CHK(par_cfg, 4'h2)
    wr(`DCP_ADDR_PAR, 32'h8);
    settle;
    `CHK(par_cfg, 4'h1)
    wr(`DCP_ADDR_CMD, 32'h8);
    rd(`DCP_ADDR_PAR, 32'h0);
  endtask

  task automatic t_blt;
    int i;
    wr(`DCP_ADDR_IRQ_STAT, 32'hF);
    wr(`DCP_ADDR_IRQ_MASK, 32'h8);
    @(posedge clk) user_activity <= 1'b1;
    @(posedge clk) user_activity <= 1'b0;
    settle;
    `CHK(backlight_on, 1'b1)
    i = 0;
    while (backlight_on === 1'b1 && i < 40)
    begin
      @(posedge clk);
      #1 i++;
    end
    `CHK(backlight_on, 1'b0)
    `CHK(i inside {[16:23]}, 1'b1)
    `CHK(irq, 1'b1)
    wr(`DCP_ADDR_CTRL, 32'h08);
    @(posedge clk) user_activity <= 1'b1;
    @(posedge clk) user_activity <= 1'b0;
    wr(`DCP_ADDR_IRQ_STAT, 32'h8);
    settle;
    `CHK(irq, 1'b0)
    repeat (40) @(posedge clk);
    #1 `CHK(backlight_on, 1'b1)
  endtask

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      stop_test;
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_power;
    t_supply;
    t_heat;
    t_remote(32'h18, 1'b1, 1'b0);
    t_remote(32'h1C, 1'b1, 1'b1);
    t_remote(32'h1C, 1'b0, 1'b0);
    t_par;
    t_blt;
    stop_test;
  end
endmodule // testbench
